/* hpw_pkg.sv */
// Package for the host port write block: widths, states, carrier structs.
// Assumes a single core clock; nothing here is timing critical.
package hpw_pkg;

  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 4;
  localparam int SYNC_STAGES = 3;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // One-hot cycle sequencer states
  typedef enum logic [3:0] {
    HPW_IDLE = 4'b0001,
    HPW_ACK = 4'b0010,
    HPW_RELEASE = 4'b0100,
    HPW_WAIT_START = 4'b1000
  } hpw_state_e;

  // Host pins as seen by the device
  typedef struct packed {
    logic chip_select_n;
    logic read_not_write;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] data_bus;
  } hpw_pins_s;

  // Ready pin drive: level and output enable
  typedef struct packed {
    logic ready_n;
    logic ready_oe;
  } hpw_ready_s;

endpackage

/* hpw_host_write.sv */
// Write side of the asynchronous 8-bit parallel host port.
// Assumes host pins are asynchronous to clk_in and ready has an external pullup.
`timescale 1ns/1ps

// Notes on behaviour
// - A write starts on the falling edge of chip select with all other lines already valid.
// - The device pulls ready low once it has taken the byte.
// - On chip select rising, ready is driven high for one clock and then released.
// - No clock is shared with the host; chip select and ready alone sequence the cycle.
module hpw_host_write #(
  parameter int NUM_REGS = hpw_pkg::NUM_REGS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic host_chip_select_n_in,
  input wire logic host_read_not_write_in,
  input wire logic [hpw_pkg::ADDR_W-1:0] host_reg_addr_in,
  input wire logic [hpw_pkg::DATA_W-1:0] host_data_bus_in,
  output logic host_ready_n_out,
  output logic host_ready_oe_out,
  output logic [NUM_REGS*hpw_pkg::DATA_W-1:0] host_regs_out,
  output logic write_strobe_out
);

  typedef struct packed {
    logic cs_low;
    hpw_pkg::hpw_state_e state;
    hpw_pkg::hpw_ready_s ready;
    logic [NUM_REGS*hpw_pkg::DATA_W-1:0] regs;
    logic strobe;
  } hpw_core_s;

  hpw_core_s cur;
  hpw_core_s next_cur;
  hpw_pkg::hpw_pins_s pins;
  logic next_cs_low;
  logic cs_fall;
  logic cs_rise;
  logic is_write;
  logic cs_seen_n;
  logic rnw_seen;
  logic [hpw_pkg::ADDR_W-1:0] addr_seen;
  logic [hpw_pkg::DATA_W-1:0] data_seen;

  // Chip select, idle high
  hpw_pin_filter #(
    .WIDTH(1),
    .IDLE_LEVEL(1'b1)
  ) u_cs_filter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(host_chip_select_n_in),
    .level_out(cs_seen_n)
  );

  // Direction, idle high
  hpw_pin_filter #(
    .WIDTH(1),
    .IDLE_LEVEL(1'b1)
  ) u_rnw_filter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(host_read_not_write_in),
    .level_out(rnw_seen)
  );

  // Register address
  hpw_pin_filter #(
    .WIDTH(hpw_pkg::ADDR_W),
    .IDLE_LEVEL('0)
  ) u_addr_filter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(host_reg_addr_in),
    .level_out(addr_seen)
  );

  // Write byte
  hpw_pin_filter #(
    .WIDTH(hpw_pkg::DATA_W),
    .IDLE_LEVEL('0)
  ) u_data_filter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(host_data_bus_in),
    .level_out(data_seen)
  );

  assign pins.chip_select_n = cs_seen_n;
  assign pins.read_not_write = rnw_seen;
  assign pins.reg_addr = addr_seen;
  assign pins.data_bus = data_seen;

  always_comb
  begin
    next_cur = cur;
    // Filtered pins; edges are found against the registered level
    next_cs_low = ~pins.chip_select_n;
    next_cur.cs_low = next_cs_low;
    cs_fall = next_cs_low && !cur.cs_low;
    cs_rise = !next_cs_low && cur.cs_low;
    is_write = ~pins.read_not_write;
    next_cur.strobe = 1'b0;
    case (cur.state)
      hpw_pkg::HPW_IDLE:
      begin
        next_cur.ready = '{ready_n: 1'b1, ready_oe: 1'b0};
        if (cs_fall && is_write)
        begin
          // Pins were stable since before the edge and stay so until ready
          for (int i = 0; i < NUM_REGS; i++)
          begin
            if (pins.reg_addr == i[hpw_pkg::ADDR_W-1:0])
            begin
              next_cur.regs[i*hpw_pkg::DATA_W +: hpw_pkg::DATA_W] = pins.data_bus;
            end
          end
          next_cur.strobe = 1'b1;
          next_cur.ready = '{ready_n: 1'b0, ready_oe: 1'b1};
          next_cur.state = hpw_pkg::HPW_ACK;
        end
        else if (cs_fall)
        begin
          // Read cycles belong to another block; wait for the end
          next_cur.state = hpw_pkg::HPW_WAIT_START;
        end
      end
      hpw_pkg::HPW_ACK:
      begin
        if (cs_rise)
        begin
          next_cur.ready = '{ready_n: 1'b1, ready_oe: 1'b1};
          next_cur.state = hpw_pkg::HPW_RELEASE;
        end
      end
      hpw_pkg::HPW_RELEASE:
      begin
        next_cur.ready = '{ready_n: 1'b1, ready_oe: 1'b0};
        next_cur.state = hpw_pkg::HPW_IDLE;
      end
      hpw_pkg::HPW_WAIT_START:
      begin
        if (cs_rise)
        begin
          next_cur.state = hpw_pkg::HPW_IDLE;
        end
      end
      default:
      begin
        next_cur.state = hpw_pkg::HPW_IDLE;
        next_cur.ready = '{ready_n: 1'b1, ready_oe: 1'b0};
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cur.cs_low <= 1'b0;
      cur.state <= hpw_pkg::HPW_IDLE;
      cur.ready <= '{ready_n: 1'b1, ready_oe: 1'b0};
      cur.regs <= {NUM_REGS{hpw_pkg::REG_RESET}};
      cur.strobe <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign host_ready_n_out = cur.ready.ready_n;
  assign host_ready_oe_out = cur.ready.ready_oe;
  assign host_regs_out = cur.regs;
  assign write_strobe_out = cur.strobe;

endmodule

// One filter per host pin group: three flip-flops per bit plus a held level, and a new level counts
// once the second and third stages agree
module hpw_pin_filter #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [hpw_pkg::SYNC_STAGES-1:0][WIDTH-1:0] stages;
    logic [WIDTH-1:0] held;
  } hpw_filter_s;

  hpw_filter_s cur;
  hpw_filter_s next_cur;
  logic [WIDTH-1:0] agreed;

  always_comb
  begin
    next_cur = cur;
    next_cur.stages = {cur.stages[hpw_pkg::SYNC_STAGES-2:0], pin_in};
    agreed = cur.held;
    if (cur.stages[hpw_pkg::SYNC_STAGES-1] == cur.stages[hpw_pkg::SYNC_STAGES-2])
    begin
      agreed = cur.stages[hpw_pkg::SYNC_STAGES-1];
    end
    next_cur.held = agreed;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cur.stages <= {hpw_pkg::SYNC_STAGES{IDLE_LEVEL}};
      cur.held <= IDLE_LEVEL;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign level_out = agreed;

endmodule

/* hpw_assertions.sv */
// Checker for the host port write handshake.
// Sees only ports of the top module.
`timescale 1ns/1ps
module hpw_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic host_chip_select_n_in,
  input wire logic host_read_not_write_in,
  input wire logic host_ready_n_out,
  input wire logic host_ready_oe_out,
  input wire logic write_strobe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_end;
    host_ready_n_out && host_ready_oe_out ##1 !host_ready_oe_out;
  endsequence
  property p_ack;
    $fell(host_chip_select_n_in) && !host_read_not_write_in |-> ##[1:5] !host_ready_n_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_str;
    $fell(host_ready_n_out) |-> write_strobe_out && host_ready_oe_out ##1 !write_strobe_out;
  endproperty
  a_str: assert property (p_str) else $error("bad strobe");
  property p_rise;
    $rose(host_chip_select_n_in) && !host_ready_n_out |-> ##[1:5] s_end;
  endproperty
  a_rise: assert property (p_rise) else $error("no release");
  property p_rel;
    $rose(host_ready_n_out) |-> s_end;
  endproperty
  a_rel: assert property (p_rel) else $error("bad high pulse");
  property p_rd;
    $fell(host_chip_select_n_in) && host_read_not_write_in |-> !write_strobe_out[*6];
  endproperty
  a_rd: assert property (p_rd) else $error("read wrote");
endmodule

/* hpw_host_model.sv */
// Host side model of the parallel port.
// Ready is resolved with a pullup by the bench.
`timescale 1ns/1ps
module hpw_host_model (
  input wire logic clk_in,
  input wire logic ready_n_in,
  output hpw_pkg::hpw_pins_s pins_out
);
  initial pins_out = '{1'b1, 1'b1, 2'h0, 8'h00};
  task automatic cyc(input logic rnw, input logic [1:0] a, input logic [7:0] d, input int lag,
    output logic acked);
    int n;
    @(posedge clk_in) #1;
    pins_out = '{1'b0, rnw, a, d};
    n = 0;
    acked = 1'b0;
    while (!acked && n < 12)
    begin
      @(posedge clk_in);
      acked = (ready_n_in === 1'b0);
      n++;
    end
    repeat (lag) @(posedge clk_in);
    #1;
    pins_out = '{1'b1, ~rnw, ~a, ~d};
    repeat (6) @(posedge clk_in);
  endtask
endmodule

/* tb.sv */
// Testbench for the host port write block.
// Host pins come from the partner model.
`timescale 1ns/1ps
module tb;
  logic clk_in = 0;
  logic rst_in = 1;
  logic rdy, oe, stb;
  logic ack;
  logic [31:0] regs, exp;
  hpw_pkg::hpw_pins_s p;
  int n_fail = 0;
  int checked = 0;
  int n_wr = 0;
  wire ready = oe ? rdy : 1'b1;
  hpw_host_write u_dut (.clk_in, .rst_in, .host_chip_select_n_in(p.chip_select_n),
    .host_read_not_write_in(p.read_not_write), .host_reg_addr_in(p.reg_addr),
    .host_data_bus_in(p.data_bus), .host_ready_n_out(rdy), .host_ready_oe_out(oe),
    .host_regs_out(regs), .write_strobe_out(stb));
  hpw_host_model u_host (.clk_in, .ready_n_in(ready), .pins_out(p));
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) if (stb === 1'b1) n_wr <= n_wr + 1;
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_wr;
    for (int a = 0; a < 4; a++)
    begin
      u_host.cyc(1'b0, a[1:0], 8'hA0 + a[7:0], 0, ack);
      chk("ack", 1, ack);
      exp[8*a +: 8] = 8'hA0 + a[7:0];
      chk("regs", exp, regs);
    end
    chk("writes", 4, n_wr);
  endtask
  task t_rd;
    u_host.cyc(1'b1, 2'h1, 8'h33, 0, ack);
    chk("ack", 0, ack);
    chk("regs", exp, regs);
    chk("writes", 4, n_wr);
  endtask
  task t_slow;
    u_host.cyc(1'b0, 2'h2, 8'h5C, 6, ack);
    chk("ack", 1, ack);
    exp[23:16] = 8'h5C;
    chk("regs", exp, regs);
    chk("writes", 5, n_wr);
  endtask
  task t_rst;
    @(posedge clk_in) #1 rst_in = 1;
    repeat (2) @(posedge clk_in);
    #1 rst_in = 0;
    chk("regs", 0, regs);
    chk("oe", 0, oe);
    chk("ready", 1, rdy);
    exp = 0;
    u_host.cyc(1'b0, 2'h3, 8'hC3, 0, ack);
    chk("ack", 1, ack);
    exp[31:24] = 8'hC3;
    chk("regs", exp, regs);
    chk("writes", 6, n_wr);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    #1 rst_in = 0;
    exp = 0;
    t_wr;
    t_rd;
    t_slow;
    t_rst;
    conclude;
  end
  initial
  begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule
bind hpw_host_write hpw_assertions u_chk (.clk_in, .rst_in, .host_chip_select_n_in,
  .host_read_not_write_in, .host_ready_n_out, .host_ready_oe_out, .write_strobe_out);
